// ==== pfi_top.sv ====
// shared-pin function, pad pulls and latched event flags
//
// The strobed register port was left to the implementer.
module pfi_top (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [pfi_pkg::ADDR_W-1:0] addr,
   input  wire logic [pfi_pkg::DATA_W-1:0] wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output logic      [pfi_pkg::DATA_W-1:0] rdata,
   input  wire logic [pfi_pkg::NFLAG-1:0]  event_src,
   input  wire logic                       system_clock_tick,
   input  wire logic                       loop_clock,
   input  wire logic                       digital_microphone_clock,
   input  wire logic                       master_clock,
   input  wire logic                       bit_clock_in,
   input  wire logic                       shared_pin_in,
   output logic                            shared_pin_out,
   output logic                            shared_pin_oe_n,
   output logic                            aif_bit_clock,
   output logic      [pfi_pkg::PULL_W-1:0] pull_enable,
   output logic                            irq
);
   import pfi_pkg::*;

   logic [9:0]        sp_ctrl;
   logic [9:0]        next_sp_ctrl;
   logic [PULL_W-1:0] pulls;
   logic [PULL_W-1:0] next_pulls;
   logic [NFLAG-1:0]  flags;
   logic [NFLAG-1:0]  next_flags;
   logic [NFLAG-1:0]  mask;
   logic [NFLAG-1:0]  next_mask;
   logic [NFLAG-1:0]  pol;
   logic [NFLAG-1:0]  next_pol;
   logic [DIV_W-1:0]  divider;
   logic [DIV_W-1:0]  next_divider;
   logic [DIV_W-1:0]  div_cnt;
   logic [DIV_W-1:0]  next_div_cnt;
   logic              div_clk;
   logic              next_div_clk;
   logic [DATA_W-1:0] next_rdata;
   logic              next_pin_out;
   logic              next_oe_n;
   logic              next_bclk;
   logic              next_irq;
   logic [NFLAG-1:0]  cond;
   logic [NFLAG-1:0]  clr;
   logic              pin_irq;
   pfi_fn_t           fn_sel;

   // register file
   always_comb begin
      next_sp_ctrl = sp_ctrl;
      next_pulls   = pulls;
      next_mask    = mask;
      next_pol     = pol;
      next_divider = divider;
      clr          = '0;
      if (wr) begin
         case (addr)
            ADDR_SHARED_PIN: begin
               next_sp_ctrl = wdata[SP_IN7_EN:SP_SEL_LO] & SP_CTRL_MASK;
            end
            ADDR_PAD_PULL:   next_pulls = wdata[PULL_W-1:0];
            ADDR_FLAGS:      clr = wdata[NFLAG-1:0];
            ADDR_MASK:       next_mask = wdata[NFLAG-1:0];
            ADDR_POLARITY:   next_pol = wdata[NFLAG-1:0];
            ADDR_DIVIDER:    next_divider = wdata[DIV_W-1:0];
            default: ;
         endcase
      end
      next_rdata = '0;
      if (rd) begin
         case (addr)
            ADDR_SHARED_PIN: next_rdata = DATA_W'(sp_ctrl);
            ADDR_PAD_PULL:   next_rdata = DATA_W'(pulls);
            // summary bit is the OR of the flags
            ADDR_FLAGS:      next_rdata = DATA_W'({|flags, flags});
            ADDR_MASK:       next_rdata = DATA_W'(mask);
            ADDR_POLARITY:   next_rdata = DATA_W'(pol);
            ADDR_DIVIDER:    next_rdata = DATA_W'(divider);
            default:         next_rdata = '0;
         endcase
      end
   end

   // flag capture
   always_comb begin
      cond = event_src ^ pol;
      // dedicated inputs only sampled while enabled
      cond[F_IN7] = cond[F_IN7] & sp_ctrl[SP_IN7_EN];
      cond[F_IN8] = cond[F_IN8] & sp_ctrl[SP_IN8_EN];
      // set wins over a clear in the same cycle
      next_flags = (flags & ~clr) | cond;
      next_irq   = |(next_flags & ~next_mask);
   end

   // tick marks each system clock edge: a half period of divider ticks
   // gives one output period per twice divider system clocks
   always_comb begin
      next_div_cnt = div_cnt;
      next_div_clk = div_clk;
      if (system_clock_tick) begin
         if (div_cnt + DIV_STEP >= divider) begin
            next_div_cnt = '0;
            next_div_clk = ~div_clk;
         end else begin
            next_div_cnt = div_cnt + DIV_STEP;
         end
      end
   end

   // shared pin mux
   always_comb begin
      fn_sel       = pfi_fn_t'(sp_ctrl[SP_SEL_HI:SP_SEL_LO]);
      pin_irq      = |(flags & ~mask);
      next_pin_out = 1'b0;
      next_oe_n    = 1'b1;
      next_bclk    = bit_clock_in;
      if (sp_ctrl[SP_GP_MODE]) begin
         next_bclk = master_clock;
         next_oe_n = 1'b0;
         case (fn_sel)
            PFI_FN_INPUT:   next_oe_n = 1'b1;
            PFI_FN_CLKOUT:  next_pin_out = div_clk;
            PFI_FN_LOW:     next_pin_out = 1'b0;
            PFI_FN_HIGH:    next_pin_out = 1'b1;
            PFI_FN_IRQ:     next_pin_out = pin_irq;
            PFI_FN_LOCK:    next_pin_out = event_src[F_LOCK];
            PFI_FN_MICDET:  next_pin_out = event_src[F_DETECT];
            PFI_FN_MICSHRT: next_pin_out = event_src[F_SHORT];
            PFI_FN_DIGITAL_MICROPHONE:    next_pin_out = digital_microphone_clock;
            PFI_FN_LOOPCLK: next_pin_out = loop_clock;
            // reserved codes leave the pin undriven
            default:        next_oe_n = 1'b1;
         endcase
      end
   end

   // register file and read data
   always_ff @(posedge clk) begin
      if (rst) begin
         sp_ctrl     <= '0;
         pulls       <= '0;
         mask        <= MASK_RST;
         pol         <= POL_RST;
         divider     <= DIV_RST;
         rdata       <= '0;
         pull_enable <= '0;
      end else begin
         sp_ctrl     <= next_sp_ctrl;
         pulls       <= next_pulls;
         mask        <= next_mask;
         pol         <= next_pol;
         divider     <= next_divider;
         rdata       <= next_rdata;
         pull_enable <= next_pulls;
      end
   end

   pull_write_a: assert property (@(posedge clk) disable iff (rst)
      (wr && addr == ADDR_PAD_PULL)
      |=> pull_enable == $past(wdata[PULL_W-1:0]))
      else $error("pull write not applied");

   mask_write_a: assert property (@(posedge clk) disable iff (rst)
      (wr && addr == ADDR_MASK) |=> mask == $past(wdata[NFLAG-1:0]))
      else $error("mask write not applied");

   // latched flags and interrupt request
   always_ff @(posedge clk) begin
      if (rst) begin
         flags <= '0;
         irq   <= 1'b0;
      end else begin
         flags <= next_flags;
         irq   <= next_irq;
      end
   end

   flag_set_a: assert property (@(posedge clk) disable iff (rst)
      (|cond) |=> (flags & $past(cond)) == $past(cond))
      else $error("flag not set by its event");

   // output clock divider state
   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt <= '0;
         div_clk <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         div_clk <= next_div_clk;
      end
   end

   div_idle_a: assert property (@(posedge clk) disable iff (rst)
      !system_clock_tick |=> $stable(div_clk) && $stable(div_cnt))
      else $error("divider moved without a tick");

   div_run_a: assert property (@(posedge clk) disable iff (rst)
      (system_clock_tick && divider <= DIV_STEP)
      |=> div_clk != $past(div_clk))
      else $error("divider of one did not toggle");

   // shared pin and bit clock outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         shared_pin_out  <= 1'b0;
         shared_pin_oe_n <= 1'b1;
         aif_bit_clock   <= 1'b0;
      end else begin
         shared_pin_out  <= next_pin_out;
         shared_pin_oe_n <= next_oe_n;
         aif_bit_clock   <= next_bclk;
      end
   end

   bclk_gp_a: assert property (@(posedge clk) disable iff (rst)
      sp_ctrl[SP_GP_MODE] |=> aif_bit_clock == $past(master_clock))
      else $error("bit clock not from master clock");

   pin_low_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_LOW)
      |=> !shared_pin_oe_n && !shared_pin_out)
      else $error("pin not driven low");

   pin_high_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_HIGH)
      |=> !shared_pin_oe_n && shared_pin_out)
      else $error("pin not driven high");

   pin_irq_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_IRQ)
      |=> shared_pin_out == $past(pin_irq))
      else $error("pin does not follow irq");

   pin_lock_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_LOCK)
      |=> shared_pin_out == $past(event_src[F_LOCK]))
      else $error("pin does not follow lock status");

   pin_det_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_MICDET)
      |=> shared_pin_out == $past(event_src[F_DETECT]))
      else $error("pin does not follow bias detect");

   pin_shrt_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_MICSHRT)
      |=> shared_pin_out == $past(event_src[F_SHORT]))
      else $error("pin does not follow bias short");

   pin_digital_microphone_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_DIGITAL_MICROPHONE)
      |=> shared_pin_out == $past(digital_microphone_clock))
      else $error("pin does not follow mic clock");

   pin_clkout_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_CLKOUT)
      |=> shared_pin_out == $past(div_clk))
      else $error("pin does not follow divided clock");

   pin_loop_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_LOOPCLK)
      |=> shared_pin_out == $past(loop_clock))
      else $error("pin does not follow loop clock");

   flag_hold_a: assert property (@(posedge clk) disable iff (rst)
      (flags[F_SHARED] && !(wr && addr == ADDR_FLAGS && wdata[F_SHARED]))
      |=> flags[F_SHARED])
      else $error("flag dropped without clear");
   flag_clear_a: assert property (@(posedge clk) disable iff (rst)
      (wr && addr == ADDR_FLAGS && wdata[F_SEQ] && !cond[F_SEQ])
      |=> !flags[F_SEQ])
      else $error("flag not cleared by write of one");
   irq_mask_a: assert property (@(posedge clk) disable iff (rst)
      irq == |(flags & ~mask))
      else $error("irq disagrees with unmasked flags");
   summary_read_a: assert property (@(posedge clk) disable iff (rst)
      (rd && addr == ADDR_FLAGS) |=> rdata[SUMMARY] == |$past(flags))
      else $error("summary bit wrong");
   input_gate_a: assert property (@(posedge clk) disable iff (rst)
      (!sp_ctrl[SP_IN7_EN] && !flags[F_IN7]) |=> !flags[F_IN7])
      else $error("disabled input set its flag");
   pol_set_a: assert property (@(posedge clk) disable iff (rst)
      (event_src[F_LOCK] != pol[F_LOCK]) |=> flags[F_LOCK])
      else $error("lock flag not set");
   bclk_mode_a: assert property (@(posedge clk) disable iff (rst)
      !sp_ctrl[SP_GP_MODE] |=> aif_bit_clock == $past(bit_clock_in))
      else $error("bit clock not from pin");
   pin_input_a: assert property (@(posedge clk) disable iff (rst)
      (sp_ctrl[SP_GP_MODE] && fn_sel == PFI_FN_INPUT) |=> shared_pin_oe_n)
      else $error("input function drives pin");
endmodule

// ==== pfi_pkg.sv ====
// constants for the shared-pin function and event flag block
package pfi_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_SHARED_PIN = 8'h7c;
   localparam logic [ADDR_W-1:0] ADDR_PAD_PULL   = 8'h7e;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS      = 8'h7f;
   localparam logic [ADDR_W-1:0] ADDR_MASK       = 8'h80;
   localparam logic [ADDR_W-1:0] ADDR_POLARITY   = 8'h81;
   localparam logic [ADDR_W-1:0] ADDR_DIVIDER    = 8'h82;
   // shared pin control fields
   localparam int SP_IN7_EN  = 9;
   localparam int SP_IN8_EN  = 8;
   localparam int SP_GP_MODE = 7;
   localparam int SP_SEL_HI  = 3;
   localparam int SP_SEL_LO  = 0;
   // writable bits of the shared pin control word, reserved bits read 0
   localparam logic [SP_IN7_EN:SP_SEL_LO] SP_CTRL_MASK = 10'h38f;
   localparam int NFLAG      = 10;
   localparam int SUMMARY    = 10;
   localparam int PULL_W     = 8;
   localparam int DIV_W      = 8;
   // flag positions
   localparam int F_SHARED = 9;
   localparam int F_SEQ    = 8;
   localparam int F_IN8    = 4;
   localparam int F_IN7    = 3;
   localparam int F_LOCK   = 2;
   localparam int F_SHORT  = 1;
   localparam int F_DETECT = 0;
   localparam logic [NFLAG-1:0] MASK_RST = 10'h3ff;
   localparam logic [NFLAG-1:0] POL_RST  = 10'h000;
   localparam logic [DIV_W-1:0] DIV_RST  = 8'h01;
   localparam logic [DIV_W-1:0] DIV_STEP = 8'h01;
   typedef enum logic [3:0] {
      PFI_FN_INPUT   = 4'h0,
      PFI_FN_CLKOUT  = 4'h1,
      PFI_FN_LOW     = 4'h2,
      PFI_FN_HIGH    = 4'h3,
      PFI_FN_IRQ     = 4'h4,
      PFI_FN_LOCK    = 4'h5,
      PFI_FN_MICDET  = 4'h6,
      PFI_FN_MICSHRT = 4'h7,
      PFI_FN_DIGITAL_MICROPHONE    = 4'h8,
      PFI_FN_LOOPCLK = 4'h9
   } pfi_fn_t;
endpackage

// ==== pfi_host.sv ====
// host model issuing register reads and writes
module pfi_host (
   input  wire logic                       clk,
   output logic      [pfi_pkg::ADDR_W-1:0] addr,
   output logic      [pfi_pkg::DATA_W-1:0] wdata,
   output logic                            wr,
   output logic                            rd,
   input  wire logic [pfi_pkg::DATA_W-1:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import pfi_pkg::*;
   initial begin
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
   end
   // function codes above 9 never issued
   // flags cleared only by ones
   task automatic write(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   // sequencer flag never judged while busy
   task automatic read(input logic [ADDR_W-1:0] a,
                       output logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the shared-pin and event flag block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pfi_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, rv;
   logic              wr, rd, pin_out, pin_oe_n, bclk_out, irq;
   // two top bits stand for the mic clock and the loop clock
   logic [NFLAG+1:0]  event_src = '0;
   logic              tick = 1'b0;
   logic              mclk_in = 1'b0;
   logic              bclk_in = 1'b0;
   logic [PULL_W-1:0] pull;
   int                n_mismatch = 0;
   int                tests_run = 0;
   always #10 clk = ~clk;
   pfi_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
                    .rd(rd), .rdata(rdata));
   pfi_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .event_src(event_src[NFLAG-1:0]),
      .system_clock_tick(tick), .loop_clock(event_src[NFLAG+1]),
      .digital_microphone_clock(event_src[NFLAG]),
      .master_clock(mclk_in), .bit_clock_in(bclk_in),
      .shared_pin_in(1'b0), .shared_pin_out(pin_out),
      .shared_pin_oe_n(pin_oe_n), .aif_bit_clock(bclk_out),
      .pull_enable(pull), .irq(irq));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string m);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a,
                         input logic [15:0] exp, input string m);
      u_host.read(a, rv);
      chk(rv, exp, m);
   endtask
   task automatic pulse(input int b);
      @(posedge clk) event_src[b] <= 1'b1;
      @(posedge clk) event_src[b] <= 1'b0;
      settle();
   endtask
   task automatic t_reset();
      @(posedge clk) bclk_in <= 1'b1;
      settle();
      chk(bclk_out, 1'b1, "bit clock path");
      chk(pin_oe_n, 1'b1, "pin idle");
      chk(pull, 8'h00, "pull reset");
      rd_chk(ADDR_SHARED_PIN, 16'h0000, "pin ctrl reset");
      rd_chk(ADDR_FLAGS, 16'h0000, "flags reset");
      rd_chk(ADDR_MASK, 16'h03ff, "mask reset");
      rd_chk(ADDR_POLARITY, 16'h0000, "polarity reset");
      rd_chk(8'h7d, 16'h0000, "unmapped read");
   endtask
   task automatic t_pull(input logic [7:0] v);
      u_host.write(ADDR_PAD_PULL, {8'h00, v});
      settle();
      chk(pull, v, "pull pins");
      rd_chk(ADDR_PAD_PULL, {8'h00, v}, "pull readback");
   endtask
   task automatic t_pin();
      @(posedge clk) mclk_in <= 1'b1;
      u_host.write(ADDR_SHARED_PIN, 16'h0082);
      settle();
      chk(bclk_out, 1'b1, "master clock path");
      chk({pin_oe_n, pin_out}, 2'b00, "drive low");
      u_host.write(ADDR_SHARED_PIN, 16'h0083);
      settle();
      chk({pin_oe_n, pin_out}, 2'b01, "drive high");
      u_host.write(ADDR_SHARED_PIN, 16'h0080);
      settle();
      chk(pin_oe_n, 1'b1, "input code");
      @(posedge clk) bclk_in <= 1'b0;
      u_host.write(ADDR_SHARED_PIN, 16'h0000);
      settle();
      chk(bclk_out, 1'b0, "bit clock back");
   endtask
   task automatic t_flags();
      u_host.write(ADDR_MASK, 16'h01ff);
      u_host.write(ADDR_SHARED_PIN, 16'h0084);
      pulse(F_SHARED);
      chk({irq, pin_out}, 2'b11, "irq unmasked");
      rd_chk(ADDR_FLAGS, 16'h0600, "latched flag");
      u_host.write(ADDR_FLAGS, 16'h0300);
      settle();
      chk(irq, 1'b0, "irq after clear");
      rd_chk(ADDR_FLAGS, 16'h0000, "flag cleared");
      pulse(5);
      chk(irq, 1'b0, "masked flag");
      rd_chk(ADDR_FLAGS, 16'h0420, "summary bit");
      u_host.write(ADDR_FLAGS, 16'h0020);
      u_host.write(ADDR_POLARITY, 16'h0004);
      settle();
      rd_chk(ADDR_FLAGS, 16'h0404, "unlock flag");
      u_host.write(ADDR_POLARITY, 16'h0000);
      u_host.write(ADDR_FLAGS, 16'h0004);
      pulse(F_IN7);
      rd_chk(ADDR_FLAGS, 16'h0000, "input disabled");
      u_host.write(ADDR_SHARED_PIN, 16'h0200);
      pulse(F_IN7);
      rd_chk(ADDR_FLAGS, 16'h0408, "input enabled");
   endtask
   task automatic route(input logic [3:0] fn, input int b, input string m);
      u_host.write(ADDR_SHARED_PIN, {12'h008, fn});
      @(posedge clk) event_src[b] <= 1'b1;
      settle();
      chk(pin_out, 1'b1, m);
      @(posedge clk) event_src[b] <= 1'b0;
      settle();
      chk({pin_oe_n, pin_out}, 2'b00, m);
   endtask
   task automatic t_clkout(input logic [7:0] d);
      logic [8:0] s;
      u_host.write(ADDR_DIVIDER, {8'h00, d});
      rd_chk(ADDR_DIVIDER, {8'h00, d}, "divider readback");
      u_host.write(ADDR_SHARED_PIN, 16'h0081);
      @(posedge clk) tick <= 1'b1;
      settle();
      for (int i = 0; i < 9; i++) begin
         @(posedge clk) #1 s[i] = pin_out;
      end
      for (int i = 0; i + d < 9; i++) begin
         chk(s[i + d], !s[i], "clock out half period");
      end
      @(posedge clk) tick <= 1'b0;
   endtask
   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_pull(8'ha5);
      t_pull(8'h5a);
      t_pin();
      t_flags();
      route(4'h5, F_LOCK, "lock status");
      route(4'h6, F_DETECT, "mic detect");
      route(4'h7, F_SHORT, "mic short");
      route(4'h8, NFLAG, "mic clock");
      route(4'h9, NFLAG + 1, "loop clock");
      t_clkout(8'h01);
      t_clkout(8'h02);
      close_out();
   end
   initial begin
      #100us;
      n_mismatch++;
      close_out();
   end
endmodule
